// ### verilog/bstap_consts.svh
`ifndef BSTAP_CONSTS_SVH
`define BSTAP_CONSTS_SVH
// ----------------------------------------------------------------------------
// Boundary-scan port constants.
// ----------------------------------------------------------------------------
`define BSTAP_IR_W          3
`define BSTAP_IR_EXTEST     3'h0
`define BSTAP_IR_SAMPLE     3'h4
`define BSTAP_IR_IDCODE     3'h6
`define BSTAP_IR_BYPASS     3'h7
`define BSTAP_IR_CAPTURE    3'h1
`define BSTAP_CHAIN_LEN     98
`define BSTAP_ID_W          32
`define BSTAP_RESET_ONES    5
`define BSTAP_PRODUCER      11'h001
`define BSTAP_PART          16'h0001
`define BSTAP_REVISION      4'h1
`endif

// ### verilog/bstap_pkg.sv
// ----------------------------------------------------------------------------
// Types shared by the boundary-scan port.
// ----------------------------------------------------------------------------
package bstap_pkg;
    typedef enum logic [3:0] {
        BSTAP_RESET, BSTAP_IDLE, BSTAP_SEL_DR, BSTAP_CAP_DR, BSTAP_SHIFT_DR,
        BSTAP_EXIT1_DR, BSTAP_PAUSE_DR, BSTAP_EXIT2_DR, BSTAP_UPD_DR,
        BSTAP_SEL_IR, BSTAP_CAP_IR, BSTAP_SHIFT_IR, BSTAP_EXIT1_IR,
        BSTAP_PAUSE_IR, BSTAP_EXIT2_IR, BSTAP_UPD_IR
    } bstap_state_t;
    typedef enum logic [1:0] {
        BSTAP_SEL_CHAIN, BSTAP_SEL_ID, BSTAP_SEL_PASS
    } bstap_dsel_t;
endpackage

// ### verilog/bstap_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Two-stage synchroniser for one outside level.
// ----------------------------------------------------------------------------
module bstap_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### verilog/bstap_top.sv
// Summary of operation
// RULE_01: Controlled only by mode select and test clock. The code also forces the reset state from rst_n.
// RULE_02: Three-bit instruction, shifted least bit first.
// RULE_03: EXTEST selects chain, captures input pins.
// RULE_04: EXTEST drives output pins from update latch.
// RULE_05: SAMPLE selects chain, captures, core paths kept.
// RULE_06: IDCODE places identification word in path.
// RULE_07: BYPASS gives one-stage, one-clock delay path.
// RULE_08: Identification word fields: one, producer, part, revision.
// RULE_09: Identification word shifts out least bit first.
// RULE_10: Boundary chain is 98 bits over pins.
// RULE_11: Sixteen-state controller, standard state graph.
// RULE_12: Transitions use mode select at rising edge.
// RULE_13: Five high mode-select edges force reset.
// RULE_14: Reset state disables test, loads IDCODE.
// RULE_15: Update latch loads on falling edge only.
// RULE_16: Shift advances selected register each rising edge.
// RULE_17: Undefined codes decode as BYPASS.
// RULE_18: Data output driven only in shift states.
`timescale 1ns/10ps
`default_nettype none
`include "bstap_consts.svh"
module bstap_top #(
    parameter int CHAIN_LEN = `BSTAP_CHAIN_LEN,
    parameter int NIN       = 49
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    output var  logic                       tdo,
    output var  logic                       tdo_oe,
    input  wire logic [NIN-1:0]             pin_in,
    input  wire logic [CHAIN_LEN-NIN-1:0]   core_out,
    output var  logic [CHAIN_LEN-NIN-1:0]   pin_out,
    output var  logic [NIN-1:0]             core_in,
    output var  logic                       test_active,
    output var  bstap_pkg::bstap_state_t    tap_state
);
    import bstap_pkg::*;
    localparam int NOUT = CHAIN_LEN - NIN;

    // ------------------------------------------------------------------------
    // Synchronisers and test-clock edge detection.
    // ------------------------------------------------------------------------
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_d_reg;

    bstap_sync u_tck (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(tck), .sync_out(tck_s)); // RULE_01
    bstap_sync u_tms (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(tms), .sync_out(tms_s));
    bstap_sync u_tdi (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(tdi), .sync_out(tdi_s));

    // ------------------------------------------------------------------------
    // Input pins pass two stages before the boundary chain captures them.
    // ------------------------------------------------------------------------
    wire [NIN-1:0] pin_in_s;

    // One synchroniser per input pin, so a capture never sees a raw pin level.
    for (genvar g = 0; g < NIN; g++) begin : gen_pin_sync
        bstap_sync u_pin (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .async_in(pin_in[g]),
            .sync_out(pin_in_s[g])
        );
    end

    // Previous test-clock level.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) tck_d_reg <= 1'b0;
        else tck_d_reg <= tck_s;
    end

    wire rise = tck_s & ~tck_d_reg;
    wire fall = ~tck_s & tck_d_reg;

    // ------------------------------------------------------------------------
    // Controller state graph.
    // ------------------------------------------------------------------------
    bstap_state_t state_reg;
    bstap_state_t state_next;

    // Next state from the mode-select level at the rising edge.
    always_comb begin
        unique case (state_reg) // RULE_11
            BSTAP_RESET:    state_next = tms_s ? BSTAP_RESET    : BSTAP_IDLE; // RULE_13
            BSTAP_IDLE:     state_next = tms_s ? BSTAP_SEL_DR   : BSTAP_IDLE;
            BSTAP_SEL_DR:   state_next = tms_s ? BSTAP_SEL_IR   : BSTAP_CAP_DR;
            BSTAP_CAP_DR:   state_next = tms_s ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
            BSTAP_SHIFT_DR: state_next = tms_s ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
            BSTAP_EXIT1_DR: state_next = tms_s ? BSTAP_UPD_DR   : BSTAP_PAUSE_DR;
            BSTAP_PAUSE_DR: state_next = tms_s ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
            BSTAP_EXIT2_DR: state_next = tms_s ? BSTAP_UPD_DR   : BSTAP_SHIFT_DR;
            BSTAP_UPD_DR:   state_next = tms_s ? BSTAP_SEL_DR   : BSTAP_IDLE;
            BSTAP_SEL_IR:   state_next = tms_s ? BSTAP_RESET    : BSTAP_CAP_IR;
            BSTAP_CAP_IR:   state_next = tms_s ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
            BSTAP_SHIFT_IR: state_next = tms_s ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
            BSTAP_EXIT1_IR: state_next = tms_s ? BSTAP_UPD_IR   : BSTAP_PAUSE_IR;
            BSTAP_PAUSE_IR: state_next = tms_s ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
            BSTAP_EXIT2_IR: state_next = tms_s ? BSTAP_UPD_IR   : BSTAP_SHIFT_IR;
            BSTAP_UPD_IR:   state_next = tms_s ? BSTAP_SEL_DR   : BSTAP_IDLE;
        endcase
    end

    // State advances only on a test-clock rising edge.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) state_reg <= BSTAP_RESET; // RULE_14
        else if (rise) state_reg <= state_next; // RULE_12
    end

    // ------------------------------------------------------------------------
    // Instruction register and decode.
    // ------------------------------------------------------------------------
    logic [`BSTAP_IR_W-1:0] ir_shift_reg;
    logic [`BSTAP_IR_W-1:0] ir_reg;

    // Any code without a meaning falls back to the pass stage.
    function automatic bstap_dsel_t decode_sel(input logic [`BSTAP_IR_W-1:0] code);
        if (code == `BSTAP_IR_EXTEST || code == `BSTAP_IR_SAMPLE) decode_sel = BSTAP_SEL_CHAIN;
        else if (code == `BSTAP_IR_IDCODE) decode_sel = BSTAP_SEL_ID;
        else decode_sel = BSTAP_SEL_PASS; // RULE_17
    endfunction

    wire bstap_dsel_t dsel   = decode_sel(ir_reg);
    wire              extest = (ir_reg == `BSTAP_IR_EXTEST) && (state_reg != BSTAP_RESET);
    wire              in_shdr = (state_reg == BSTAP_SHIFT_DR);
    wire              in_shir = (state_reg == BSTAP_SHIFT_IR);

    // Shift stage captures the fixed pattern, shifts in at the high end.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ir_shift_reg <= `BSTAP_IR_IDCODE;
        end else if (rise && state_reg == BSTAP_CAP_IR) begin
            ir_shift_reg <= `BSTAP_IR_CAPTURE;
        end else if (rise && in_shir) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[`BSTAP_IR_W-1:1]}; // RULE_02
        end
    end

    // Current instruction changes only at update or reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) ir_reg <= `BSTAP_IR_IDCODE;
        else if (state_reg == BSTAP_RESET) ir_reg <= `BSTAP_IR_IDCODE; // RULE_14
        else if (fall && state_reg == BSTAP_UPD_IR) ir_reg <= ir_shift_reg;
    end

    // ------------------------------------------------------------------------
    // Data registers.
    // ------------------------------------------------------------------------
    localparam logic [`BSTAP_ID_W-1:0] ID_WORD =
        {`BSTAP_REVISION, `BSTAP_PART, `BSTAP_PRODUCER, 1'b1}; // RULE_08

    logic [CHAIN_LEN-1:0]   chain_reg;
    logic [CHAIN_LEN-1:0]   latch_reg;
    logic [`BSTAP_ID_W-1:0] id_reg;
    logic                   pass_reg;

    wire cap_dr = rise && state_reg == BSTAP_CAP_DR;
    wire sh_dr  = rise && in_shdr;

    // Boundary chain: capture pins and core outputs, shift toward output.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) chain_reg <= '0;
        else if (cap_dr && dsel == BSTAP_SEL_CHAIN) chain_reg <= {core_out, pin_in_s}; // RULE_03 RULE_05
        else if (sh_dr && dsel == BSTAP_SEL_CHAIN) chain_reg <= {tdi_s, chain_reg[CHAIN_LEN-1:1]}; // RULE_10 RULE_16
    end

    // Update latch loads on the falling edge in the update state.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) latch_reg <= '0;
        else if (fall && state_reg == BSTAP_UPD_DR && dsel == BSTAP_SEL_CHAIN) latch_reg <= chain_reg; // RULE_15
    end

    // Identification word loads at capture and shifts low bit first.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) id_reg <= ID_WORD;
        else if (cap_dr && dsel == BSTAP_SEL_ID) id_reg <= ID_WORD; // RULE_06
        else if (sh_dr && dsel == BSTAP_SEL_ID) id_reg <= {tdi_s, id_reg[`BSTAP_ID_W-1:1]}; // RULE_09
    end

    // Single pass stage.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) pass_reg <= 1'b0;
        else if (cap_dr && dsel == BSTAP_SEL_PASS) pass_reg <= 1'b0;
        else if (sh_dr && dsel == BSTAP_SEL_PASS) pass_reg <= tdi_s; // RULE_07
    end

    // ------------------------------------------------------------------------
    // Serial output, launched on the falling test-clock edge.
    // ------------------------------------------------------------------------
    wire dr_bit = (dsel == BSTAP_SEL_CHAIN) ? chain_reg[0] :
                  (dsel == BSTAP_SEL_ID)    ? id_reg[0]    : pass_reg;
    wire out_bit = in_shir ? ir_shift_reg[0] : dr_bit;

    // Data output and its enable change on the falling edge.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (fall) begin
            tdo    <= out_bit;
            tdo_oe <= in_shdr | in_shir; // RULE_18
        end
    end

    // ------------------------------------------------------------------------
    // Pin multiplexing between core and boundary latch.
    // ------------------------------------------------------------------------
    wire [NOUT-1:0] pin_mux = extest ? latch_reg[CHAIN_LEN-1:NIN] : core_out; // RULE_04

    // Registered pin and core paths, plus status.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_out     <= '0;
            core_in     <= '0;
            test_active <= 1'b0;
            tap_state   <= BSTAP_RESET;
        end else begin
            pin_out     <= pin_mux;
            core_in     <= pin_in;
            test_active <= extest;
            tap_state   <= state_reg;
        end
    end
endmodule
`default_nettype wire

// ### tb/bstap_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port-level checks of the boundary-scan port.
// ----------------------------------------------------------------------------
module bstap_top_asserts #(
    parameter int CHAIN_LEN = 98,
    parameter int NIN       = 49
) (
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    input wire logic                     tdo_oe,
    input wire logic [NIN-1:0]           pin_in,
    input wire logic [CHAIN_LEN-NIN-1:0] core_out,
    input wire logic [CHAIN_LEN-NIN-1:0] pin_out,
    input wire logic [NIN-1:0]           core_in,
    input wire logic                     test_active,
    input wire bstap_pkg::bstap_state_t  tap_state
);
    import bstap_pkg::*;
    // All checks sample on the system clock; all but chk_reset_state rest while reset is held.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_reset_state: assert property (
        disable iff (1'b0) !rst_n |=> tap_state == BSTAP_RESET && !test_active)
        else $error("reset did not park the controller");
    chk_reset_idle: assert property (
        tap_state == BSTAP_RESET && $past(tap_state) == BSTAP_RESET |-> !test_active)
        else $error("test logic active in reset state");
    chk_oe_rise: assert property (
        $rose(tdo_oe) |-> tap_state inside {BSTAP_SHIFT_DR, BSTAP_SHIFT_IR})
        else $error("data output enabled outside shift");
    chk_oe_fall: assert property (
        $fell(tdo_oe) |-> !(tap_state inside {BSTAP_SHIFT_DR, BSTAP_SHIFT_IR}))
        else $error("data output released inside shift");
    chk_core_pass: assert property (
        $past(rst_n) |-> core_in == $past(pin_in))
        else $error("input pin path broken");
    chk_pin_normal: assert property (
        !test_active && $past(!test_active) && $past(rst_n) |-> pin_out == $past(core_out))
        else $error("output pins not from core");
    chk_latch_update: assert property (
        test_active && $past(test_active) && $changed(pin_out) |-> $past(tap_state) == BSTAP_UPD_DR)
        else $error("update latch moved outside update state");
    chk_sel_ir_next: assert property (
        $changed(tap_state) && $past(tap_state) == BSTAP_SEL_IR |-> tap_state inside {BSTAP_CAP_IR, BSTAP_RESET})
        else $error("bad step from instruction select");
    chk_shift_leave: assert property (
        $changed(tap_state) && $past(tap_state) == BSTAP_SHIFT_DR |-> tap_state == BSTAP_EXIT1_DR)
        else $error("bad step out of data shift");
    chk_step_spacing: assert property (
        $changed(tap_state) |=> $stable(tap_state) [*4])
        else $error("state moved without a test clock edge");
    // Main scenarios reached.
    cover property (tap_state == BSTAP_SHIFT_DR);
    cover property (tap_state == BSTAP_UPD_IR);
    cover property (test_active);
endmodule
`default_nettype wire

// ### tb/bstap_tester.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Test controller model: drives test clock, mode select and data input.
// ----------------------------------------------------------------------------
module bstap_tester (
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // The clock stands low between frames; mode select starts high.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock: levels set while low, data out read late in the high half.
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #100 tck = 1'b1;
        // A released output reads as the inverse, so a missing enable shows up.
        #95 q = tdo_oe ? tdo : ~tdo;
        #5 tck = 1'b0;
    endtask
    // Walks the controller with mode-select bits taken lowest first.
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) step(seq[i], 1'b0, q);
    endtask
    // Shifts n bits lowest first, raising mode select on the last one.
    task automatic scan(input int n, input logic [97:0] din, output logic [97:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    endtask
endmodule
`default_nettype wire

// ### tb/bstap_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "bstap_consts.svh"
module bstap_test;
    import bstap_pkg::*;
    typedef struct packed {logic [2:0] code; bstap_dsel_t sel;} bstap_row_t;
    logic sys_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, test_active;
    logic [48:0] pin_in, core_out, pin_out, core_in;
    bstap_state_t tap_state;
    int checked, miscompares;
    logic [97:0] q;
    logic [31:0] id_word = {`BSTAP_REVISION, `BSTAP_PART, `BSTAP_PRODUCER, 1'b1};
    logic [97:0] din = 98'h2_c3a5_5a3c_0f1e_9876_dead_beef;
    bstap_row_t rows [8] = '{'{3'h0, BSTAP_SEL_CHAIN}, '{3'h1, BSTAP_SEL_PASS},
        '{3'h2, BSTAP_SEL_PASS}, '{3'h3, BSTAP_SEL_PASS}, '{3'h4, BSTAP_SEL_CHAIN},
        '{3'h5, BSTAP_SEL_PASS}, '{3'h6, BSTAP_SEL_ID}, '{3'h7, BSTAP_SEL_PASS}};
    bstap_top bstap_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
        .pin_out(pin_out), .core_in(core_in), .test_active(test_active),
        .tap_state(tap_state));
    bstap_tester bstap_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));
    // Compares a shifted or parallel value.
    task automatic cmp_vec(input logic [97:0] got, input logic [97:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
        end
    endtask
    // Compares the controller state.
    task automatic cmp_state(input bstap_state_t got, input bstap_state_t exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: state %0d, wanted %0d", $time, got, exp);
        end
    endtask
    // Loads an instruction from idle and checks the captured pattern.
    task automatic ir_load(input logic [2:0] code);
        bstap_tester_i.walk(8'h03, 4);
        bstap_tester_i.scan(3, {95'h0, code}, q);
        bstap_tester_i.walk(8'h01, 2);
        cmp_vec(q, 98'h1);
    endtask
    // Runs one data scan of n bits from idle, back to idle.
    task automatic dr_scan(input int n);
        bstap_tester_i.walk(8'h01, 3);
        bstap_tester_i.scan(n, din, q);
        bstap_tester_i.walk(8'h01, 2);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // System clock at 40 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Cuts a hang short.
    initial begin
        #600_000;
        miscompares++;
        finish_test();
    end
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        pin_in = 49'h1_2345_6789_abcd;
        core_out = 49'h0_f0f0_a5a5_3c3c;
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        // Test-clock edges then fall off the system clock edges.
        #1;
        bstap_tester_i.walk(8'h00, 1);
        dr_scan(32);
        cmp_vec(q, {66'h0, id_word});
        for (int r = 0; r < 8; r++) begin
            ir_load(rows[r].code);
            dr_scan(32);
            cmp_vec(q, {66'h0, rows[r].sel == BSTAP_SEL_ID ? id_word :
                rows[r].sel == BSTAP_SEL_PASS ? {din[30:0], 1'b0} : pin_in[31:0]});
        end
        ir_load(3'h0);
        dr_scan(98);
        cmp_vec({49'h0, q[48:0]}, {49'h0, pin_in});
        cmp_vec({49'h0, pin_out}, {49'h0, din[97:49]});
        cmp_vec({97'h0, test_active}, 98'h1);
        ir_load(3'h4);
        cmp_vec({49'h0, pin_out}, {49'h0, core_out});
        bstap_tester_i.walk(8'h01, 3);
        bstap_tester_i.walk(8'h1f, 5);
        cmp_state(tap_state, BSTAP_RESET);
        bstap_tester_i.walk(8'h00, 1);
        dr_scan(32);
        cmp_vec(q, {66'h0, id_word});
        // Reset in mid-run while the boundary test is active.
        ir_load(3'h0);
        cmp_vec({97'h0, test_active}, 98'h1);
        @(posedge sys_clk);
        #1 rst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1 cmp_state(tap_state, BSTAP_RESET);
        cmp_vec({97'h0, test_active}, 98'h0);
        rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 bstap_tester_i.walk(8'h00, 1);
        cmp_vec({49'h0, pin_out}, {49'h0, core_out});
        dr_scan(32);
        cmp_vec(q, {66'h0, id_word});
        finish_test();
    end
endmodule
bind bstap_top bstap_top_asserts #(.CHAIN_LEN(CHAIN_LEN), .NIN(NIN)) bstap_top_asserts_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .tdo_oe(tdo_oe), .pin_in(pin_in),
    .core_out(core_out), .pin_out(pin_out), .core_in(core_in),
    .test_active(test_active), .tap_state(tap_state));
`default_nettype wire
